// file: src/dts_axil_slave.sv
// AXI4-Lite slave turning bus transfers into one-cycle register strobes.
// Assumes one outstanding write and one outstanding read at a time.
`include "dts_params.svh"
`default_nettype none
module dts_axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  dts_reg_if.bus rif
);
  logic aw_ff;
  logic w_ff;
  logic [5:0] awidx_ff;
  logic [7:0] wdata_ff;
  logic wbe_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [7:0] rdata_ff;
  logic [1:0] rresp_ff;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_ff & w_ff & ~bvalid_ff;
  assign s_axi_awready = ~aw_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = {24'h000000, rdata_ff};
  assign rif.wr_stb = do_write;
  assign rif.wr_be = wbe_ff;
  assign rif.wr_idx = awidx_ff;
  assign rif.wr_data = wdata_ff;
  assign rif.rd_stb = s_axi_arvalid & s_axi_arready;
  assign rif.rd_idx = s_axi_araddr[7:2];
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      aw_ff <= do_write ? 1'b0 : (aw_ff | aw_take);
      w_ff <= do_write ? 1'b0 : (w_ff | w_take);
      bvalid_ff <= do_write | (bvalid_ff & ~s_axi_bready);
      rvalid_ff <= rif.rd_stb | (rvalid_ff & ~s_axi_rready);
    end
  end
  always_ff @(posedge clk)
  begin
    if (aw_take)
      awidx_ff <= s_axi_awaddr[7:2];
    if (w_take)
    begin
      wdata_ff <= s_axi_wdata[7:0];
      wbe_ff <= s_axi_wstrb[0];
    end
    if (do_write)
      bresp_ff <= rif.wr_hit ? `DTS_RESP_OKAY : `DTS_RESP_DECERR;
    if (rif.rd_stb)
    begin
      rdata_ff <= rif.rd_data;
      rresp_ff <= rif.rd_hit ? `DTS_RESP_OKAY : `DTS_RESP_DECERR;
    end
  end
endmodule : dts_axil_slave
`default_nettype wire

// file: src/dts_params.svh
// Constants of the debug trigger, status and count block: register indices,
// field positions, reset values. Assumes byte address = 4 * register index.
//
// Contract
// - Qualify bit picks access or executed-opcode trigger
// - Begin bit: trigger starts or ends storing
// - Modes 0-4: A, A|B, A-then-B, event-B, A-then-eventB
// - Modes 5-8 full/range; 9-15 never trigger
// - Trigger register writes ignored while armed
// - End-trace reset keeps trigger bits; others default (code keeps them only while enabled with begin bit clear)
// - A hit flag sticky since arming
// - B hit flag sticky since arming
// - C hit flag sticky since arming
// - Status bit 0 mirrors arm while enabled
// - End-trace reset clears armed, keeps hit flags (code keeps flags only while enabled with begin bit clear)
// - Count field reports valid FIFO words, 0-8
// - Count saturates at eight
// - Count clears on arming, increments per capture
// - FIFO reads never change the count
// - End-trace reset keeps count; others clear (code keeps it only while enabled with begin bit clear)
// - Begin run ends at eight words; end immediate
// - Arm enables comparing and storing
`ifndef DTS_PARAMS_SVH
`define DTS_PARAMS_SVH
`define DTS_IDX_CTRL 6'h0c
`define DTS_IDX_TRIG 6'h0d
`define DTS_IDX_STAT 6'h0e
`define DTS_IDX_CNT 6'h0f
`define DTS_CTRL_EN_BIT 7
`define DTS_CTRL_ARM_BIT 6
`define DTS_TRIG_QUAL_BIT 7
`define DTS_TRIG_BEGIN_BIT 6
`define DTS_STAT_A_BIT 7
`define DTS_STAT_B_BIT 6
`define DTS_STAT_C_BIT 5
`define DTS_STAT_ARM_BIT 0
`define DTS_TRIG_RESET 8'h40
`define DTS_CNT_RESET 4'h0
`define DTS_CNT_MAX 4'h8
`define DTS_RESP_OKAY 2'h0
`define DTS_RESP_DECERR 2'h3
`endif

// file: src/dts_pkg.sv
// Types shared by the debug trigger block: trigger modes and run states.
// Assumes nothing of its surroundings.
`default_nettype none
package dts_pkg;
  typedef enum logic [3:0] {
    DTS_MODE_A_ONLY = 4'h0,
    DTS_MODE_A_OR_B = 4'h1,
    DTS_MODE_A_THEN_B = 4'h2,
    DTS_MODE_EVT_B = 4'h3,
    DTS_MODE_A_THEN_EVT_B = 4'h4,
    DTS_MODE_A_AND_B = 4'h5,
    DTS_MODE_A_NOT_B = 4'h6,
    DTS_MODE_INSIDE = 4'h7,
    DTS_MODE_OUTSIDE = 4'h8
  } dts_mode_t;
  typedef enum logic [2:0] {
    DTS_ST_IDLE = 3'b001,
    DTS_ST_WAIT = 3'b010,
    DTS_ST_FILL = 3'b100
  } dts_state_t;
endpackage : dts_pkg
`default_nettype wire

// file: src/dts_reg_if.sv
// Register access strobes between the bus slave and the register file.
// Assumes both ends run on the same clock.
`default_nettype none
interface dts_reg_if;
  logic wr_stb;
  logic wr_be;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_hit;
  logic rd_stb;
  logic [5:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_hit;
  modport bus (output wr_stb, wr_be, wr_idx, wr_data, rd_stb, rd_idx,
               input wr_hit, rd_data, rd_hit);
  modport regs (input wr_stb, wr_be, wr_idx, wr_data, rd_stb, rd_idx,
                output wr_hit, rd_data, rd_hit);
endinterface : dts_reg_if
`default_nettype wire

// file: src/dts_top.sv
// Debug trigger configuration, match status and capture count registers.
// Assumes comparator and FIFO strobes are synchronous to clk, one cycle each.
`include "dts_params.svh"
`default_nettype none
module dts_top
  import dts_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [3:0] CNT_MAX = `DTS_CNT_MAX
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic end_run_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_access,
  input wire logic comp_a_match,
  input wire logic comp_b_match,
  input wire logic comp_c_match,
  input wire logic opc_a_exec,
  input wire logic opc_b_exec,
  input wire logic range_lo_ok,
  input wire logic range_hi_ok,
  input wire logic word_captured,
  input wire logic fifo_word_read,
  output logic store_enable,
  output logic trigger_hit,
  output logic run_done
);
  // ****************************************************************
  // Bus slave
  // ****************************************************************
  dts_reg_if rif ();

  dts_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .clk(clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  logic enable_ff;
  logic arm_ff;
  logic qual_sel_ff;
  logic begin_sel_ff;
  logic [3:0] mode_ff;
  logic a_hit_ff;
  logic b_hit_ff;
  logic c_hit_ff;
  logic a_seen_ff;
  logic [3:0] cnt_ff;
  dts_state_t state_ff;
  dts_state_t nxt_state;
  logic store_en_ff;
  logic trig_hit_ff;
  logic run_done_ff;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire idx_ctrl_w = rif.wr_idx == `DTS_IDX_CTRL;
  wire idx_trig_w = rif.wr_idx == `DTS_IDX_TRIG;
  wire idx_stat_w = rif.wr_idx == `DTS_IDX_STAT;
  wire idx_cnt_w = rif.wr_idx == `DTS_IDX_CNT;
  wire wr_ok = rif.wr_stb & rif.wr_be;
  wire ctrl_wr = wr_ok & idx_ctrl_w;
  // Writes while armed are dropped silently; the bus still answers OKAY.
  wire trig_wr = wr_ok & idx_trig_w & ~arm_ff;
  wire wr_en_bit = rif.wr_data[`DTS_CTRL_EN_BIT];
  wire wr_arm_bit = rif.wr_data[`DTS_CTRL_ARM_BIT];
  // Arming needs the module enabled in the same write.
  wire arm_start = ctrl_wr & wr_en_bit & wr_arm_bit & ~arm_ff;
  assign rif.wr_hit = idx_ctrl_w | idx_trig_w | idx_stat_w | idx_cnt_w;

  wire rd_ctrl = rif.rd_idx == `DTS_IDX_CTRL;
  wire rd_trig = rif.rd_idx == `DTS_IDX_TRIG;
  wire rd_stat = rif.rd_idx == `DTS_IDX_STAT;
  wire rd_cnt = rif.rd_idx == `DTS_IDX_CNT;
  wire [7:0] ctrl_val = {enable_ff, arm_ff, 6'h00};
  wire [7:0] trig_val = {qual_sel_ff, begin_sel_ff, 2'h0, mode_ff};
  wire armed_status_flag = enable_ff & arm_ff;
  wire [7:0] stat_val = {a_hit_ff, b_hit_ff, c_hit_ff, 4'h0, armed_status_flag};
  wire [7:0] cnt_val = {4'h0, cnt_ff};
  assign rif.rd_hit = rd_ctrl | rd_trig | rd_stat | rd_cnt;
  assign rif.rd_data = rd_ctrl ? ctrl_val :
                       rd_trig ? trig_val :
                       rd_stat ? stat_val :
                       rd_cnt ? cnt_val : 8'h00;

  // ****************************************************************
  // Reset classes
  // ****************************************************************
  // An end-trace reset while enabled in end mode keeps the captured evidence so the host can read it.
  wire keep_run = end_run_rst & enable_ff & ~begin_sel_ff;
  wire full_rst = rst | (end_run_rst & ~keep_run);

  // ****************************************************************
  // Trigger qualification
  // ****************************************************************
  wire a_q = qual_sel_ff ? opc_a_exec : comp_a_match;
  wire b_q = qual_sel_ff ? opc_b_exec : comp_b_match;
  // Event-only modes take comparator B without opcode tracking.
  wire waiting = enable_ff & arm_ff & (state_ff == DTS_ST_WAIT);
  wire watching = enable_ff & arm_ff;
  logic trig_raw;

  dts_trig_decode u_decode (
    .mode(mode_ff),
    .a_q(a_q),
    .b_q(b_q),
    .b_evt(comp_b_match),
    .a_seen(a_seen_ff),
    .rng_lo(range_lo_ok),
    .rng_hi(range_hi_ok),
    .access(cpu_access),
    .fire(trig_raw)
  );

  wire trig_fire = waiting & trig_raw;
  wire cnt_full = cnt_ff == CNT_MAX;
  wire cnt_inc = store_en_ff & word_captured & ~cnt_full;
  wire fill_done = (state_ff == DTS_ST_FILL) & cnt_full;
  wire run_end = (trig_fire & ~begin_sel_ff) | fill_done;

  // ****************************************************************
  // Run sequencer
  // ****************************************************************
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      DTS_ST_IDLE:
      begin
        if (arm_start)
          nxt_state = DTS_ST_WAIT;
      end
      DTS_ST_WAIT:
      begin
        if (!watching)
          nxt_state = DTS_ST_IDLE;
        else if (trig_fire)
          nxt_state = begin_sel_ff ? DTS_ST_FILL : DTS_ST_IDLE;
      end
      DTS_ST_FILL:
      begin
        if (!watching || fill_done)
          nxt_state = DTS_ST_IDLE;
      end
      default: nxt_state = DTS_ST_IDLE;
    endcase
  end

  // End mode stores until the trigger; begin mode stores after it.
  wire nxt_store = (nxt_state == DTS_ST_FILL) |
                   ((nxt_state == DTS_ST_WAIT) & ~begin_sel_ff);

  always_ff @(posedge clk)
  begin
    if (rst || end_run_rst)
      state_ff <= DTS_ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk)
  begin
    if (rst || end_run_rst)
      store_en_ff <= 1'b0;
    else
      store_en_ff <= nxt_store;
  end

  always_ff @(posedge clk)
  begin
    if (rst || end_run_rst)
    begin
      trig_hit_ff <= 1'b0;
      run_done_ff <= 1'b0;
    end
    else
    begin
      trig_hit_ff <= trig_fire;
      run_done_ff <= run_end;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enable_ff <= 1'b0;
      arm_ff <= 1'b0;
    end
    else if (end_run_rst)
    begin
      enable_ff <= keep_run ? enable_ff : 1'b0;
      arm_ff <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      enable_ff <= wr_en_bit;
      arm_ff <= wr_en_bit & wr_arm_bit;
    end
    else if (run_end)
      arm_ff <= 1'b0;
  end

  // ****************************************************************
  // Trigger configuration
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (full_rst)
    begin
      qual_sel_ff <= 1'(`DTS_TRIG_RESET >> `DTS_TRIG_QUAL_BIT);
      begin_sel_ff <= 1'(`DTS_TRIG_RESET >> `DTS_TRIG_BEGIN_BIT);
      mode_ff <= 4'(`DTS_TRIG_RESET);
    end
    else if (trig_wr)
    begin
      qual_sel_ff <= rif.wr_data[`DTS_TRIG_QUAL_BIT];
      begin_sel_ff <= rif.wr_data[`DTS_TRIG_BEGIN_BIT];
      mode_ff <= rif.wr_data[3:0];
    end
  end

  // ****************************************************************
  // Match flags
  // ****************************************************************
  wire a_evt = watching & a_q;
  wire b_evt = watching & b_q;
  wire c_evt = watching & comp_c_match;

  // Events count only once armed, so the arming cycle itself never sets a flag.
  always_ff @(posedge clk)
  begin
    if (full_rst)
    begin
      a_hit_ff <= 1'b0;
      b_hit_ff <= 1'b0;
      c_hit_ff <= 1'b0;
    end
    else if (end_run_rst)
    begin
      a_hit_ff <= a_hit_ff;
      b_hit_ff <= b_hit_ff;
      c_hit_ff <= c_hit_ff;
    end
    else if (arm_start)
    begin
      a_hit_ff <= a_evt;
      b_hit_ff <= b_evt;
      c_hit_ff <= c_evt;
    end
    else
    begin
      a_hit_ff <= a_hit_ff | a_evt;
      b_hit_ff <= b_hit_ff | b_evt;
      c_hit_ff <= c_hit_ff | c_evt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || end_run_rst || arm_start)
      a_seen_ff <= 1'b0;
    else if (waiting && a_q)
      a_seen_ff <= 1'b1;
  end

  // ****************************************************************
  // Valid word count
  // ****************************************************************
  // FIFO read strobes are deliberately not looked at by the counter.
  logic unused_read;
  assign unused_read = fifo_word_read;

  always_ff @(posedge clk)
  begin
    if (full_rst)
      cnt_ff <= `DTS_CNT_RESET;
    else if (end_run_rst)
      cnt_ff <= cnt_ff;
    else if (arm_start)
      cnt_ff <= `DTS_CNT_RESET;
    else if (cnt_inc)
      cnt_ff <= cnt_ff + 4'h1;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign store_enable = store_en_ff;
  assign trigger_hit = trig_hit_ff;
  assign run_done = run_done_ff;
endmodule : dts_top
`default_nettype wire

// file: src/dts_trig_decode.sv
// Trigger mode decoder: turns qualified comparator matches into a trigger.
// Assumes the caller gates its output to the armed waiting phase.
`default_nettype none
module dts_trig_decode
  import dts_pkg::*;
(
  input wire logic [3:0] mode,
  input wire logic a_q,
  input wire logic b_q,
  input wire logic b_evt,
  input wire logic a_seen,
  input wire logic rng_lo,
  input wire logic rng_hi,
  input wire logic access,
  output logic fire
);
  wire in_range = access & rng_lo & rng_hi;
  always_comb
  begin
    case (mode)
      DTS_MODE_A_ONLY: fire = a_q;
      DTS_MODE_A_OR_B: fire = a_q | b_q;
      DTS_MODE_A_THEN_B: fire = a_seen & b_q;
      DTS_MODE_EVT_B: fire = b_evt;
      DTS_MODE_A_THEN_EVT_B: fire = a_seen & b_evt;
      DTS_MODE_A_AND_B: fire = a_q & b_q;
      DTS_MODE_A_NOT_B: fire = a_q & ~b_q;
      DTS_MODE_INSIDE: fire = in_range;
      DTS_MODE_OUTSIDE: fire = access & ~(rng_lo & rng_hi);
      default: fire = 1'b0;
    endcase
  end
endmodule : dts_trig_decode
`default_nettype wire

// file: testbench/dts_checker.sv
// Port-level checks of the debug trigger, status and count block.
// Assumes a bind to dts_top, every port connected by its own name.
`default_nettype none
module dts_checker #(
  parameter logic [3:0] CNT_MAX = 4'h8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic end_run_rst,
  input wire logic cpu_access,
  input wire logic comp_a_match,
  input wire logic comp_b_match,
  input wire logic opc_a_exec,
  input wire logic opc_b_exec,
  input wire logic range_lo_ok,
  input wire logic range_hi_ok,
  input wire logic word_captured,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic store_enable,
  input wire logic trigger_hit,
  input wire logic run_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************************
  // Captures counted since a begin-type trigger
  // ******************************************
  logic fill_on_ff;
  logic nxt_fill_on;
  logic [3:0] fill_cnt_ff;
  logic [3:0] nxt_fill_cnt;
  logic cause;
  assign cause = cpu_access | comp_a_match | comp_b_match | opc_a_exec | opc_b_exec
    | range_lo_ok | range_hi_ok;
  assign nxt_fill_on = store_enable && (fill_on_ff || trigger_hit);
  // Clamped like the block's own count, so the extra word at saturation is not seen.
  assign nxt_fill_cnt = !nxt_fill_on ? 4'h0
    : fill_cnt_ff + {3'h0, word_captured && fill_cnt_ff < CNT_MAX};
  always_ff @(posedge clk)
  begin
    if (rst || end_run_rst)
    begin
      fill_on_ff <= 1'b0;
      fill_cnt_ff <= 4'h0;
    end
    else
    begin
      fill_on_ff <= nxt_fill_on;
      fill_cnt_ff <= nxt_fill_cnt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence fill_full;
    fill_on_ff && store_enable && fill_cnt_ff == CNT_MAX;
  endsequence
  sequence rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  hit_pulse_a: assert property (trigger_hit |=> !trigger_hit)
    else $error("trigger_hit wider than one cycle");
  hit_split_a: assert property (trigger_hit |-> store_enable != run_done)
    else $error("trigger neither starts nor ends storing");
  done_stop_a: assert property (run_done |-> !store_enable)
    else $error("storing goes on after run end");
  fill_done_a: assert property (fill_full |-> ##[1:2] run_done)
    else $error("run not ended after eight words");
  fill_cnt_a: assert property (run_done && !trigger_hit |-> fill_cnt_ff == CNT_MAX)
    else $error("begin run ended before eight words");
  hit_cause_a: assert property (trigger_hit |-> $past(cause))
    else $error("trigger without any match");
  rd_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("unused read bits not zero");
  erst_quiet_a: assert property (end_run_rst |=> !store_enable && !trigger_hit)
    else $error("outputs active after end-run reset");
endmodule : dts_checker
bind dts_top dts_checker #(.CNT_MAX(CNT_MAX)) u_chk (.clk, .rst, .end_run_rst, .cpu_access,
  .comp_a_match, .comp_b_match, .opc_a_exec, .opc_b_exec, .range_lo_ok, .range_hi_ok,
  .word_captured, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .store_enable, .trigger_hit,
  .run_done);
`default_nettype wire

// file: testbench/dts_partner.sv
// Far-side model: trace FIFO capture strobes and the host's FIFO read-out.
// Assumes the bench loads each count with a one-cycle go strobe.
`default_nettype none
module dts_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic store_enable,
  input wire logic [3:0] cap_n,
  input wire logic cap_go,
  input wire logic [3:0] rd_n,
  input wire logic rd_go,
  output logic word_captured,
  output logic fifo_word_read
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cap_left_ff;
  logic [3:0] rd_left_ff;
  // The FIFO stores only while asked to, so a held-back count never leaks out.
  assign word_captured = store_enable && cap_left_ff != 4'h0;
  assign fifo_word_read = rd_left_ff != 4'h0;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cap_left_ff <= 4'h0;
      rd_left_ff <= 4'h0;
    end
    else
    begin
      if (cap_go) cap_left_ff <= cap_n;
      else if (word_captured) cap_left_ff <= cap_left_ff - 4'h1;
      if (rd_go) rd_left_ff <= rd_n;
      else if (fifo_word_read) rd_left_ff <= rd_left_ff - 4'h1;
    end
  end
endmodule : dts_partner
`default_nettype wire

// file: testbench/dts_top_test.sv
// Self-checking bench: AXI4-Lite register traffic, trigger stimulus, FIFO model.
// Assumes dts_top, dts_partner and dts_checker are compiled before it.
`include "dts_params.svh"
`default_nettype none
module dts_top_test import dts_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] ix_ctl = `DTS_IDX_CTRL;
  localparam logic [5:0] ix_trg = `DTS_IDX_TRIG;
  localparam logic [5:0] ix_sta = `DTS_IDX_STAT;
  localparam logic [5:0] ix_cnt = `DTS_IDX_CNT;
  localparam logic [1:0] dec = `DTS_RESP_DECERR;
  localparam logic [15:0] mask_b = 16'h000a;
  localparam logic [15:0] mask_abr = 16'h01ff;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic end_run_rst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] stim = 8'h00;
  logic [7:0] rnd;
  logic [3:0] cap_n = 4'h0;
  logic [3:0] rd_n = 4'h0;
  logic cap_go = 1'b0;
  logic rd_go = 1'b0;
  wire logic cpu_access, comp_a_match, comp_b_match, comp_c_match;
  wire logic opc_a_exec, opc_b_exec, range_lo_ok, range_hi_ok;
  logic word_captured, fifo_word_read, store_enable, trigger_hit, run_done;
  logic [33:0] rq[$];
  logic [33:0] bq[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int hits = 0;
  int dones = 0;
  int h0;
  int n;
  int m;
  assign {cpu_access, comp_a_match, comp_b_match, comp_c_match} = stim[7:4];
  assign {opc_a_exec, opc_b_exec, range_lo_ok, range_hi_ok} = stim[3:0];
  dts_top uut (.clk, .rst, .end_run_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_access, .comp_a_match, .comp_b_match, .comp_c_match,
    .opc_a_exec, .opc_b_exec, .range_lo_ok, .range_hi_ok, .word_captured, .fifo_word_read,
    .store_enable, .trigger_hit, .run_done);
  dts_partner u_far (.clk, .rst, .store_enable, .cap_n, .cap_go, .rd_n, .rd_go,
    .word_captured, .fifo_word_read);
  always #4 clk = ~clk;
  // *****************************************
  // Checking, closing report and bus tasks
  // *****************************************
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic tmo(input int k);
    if (k >= 64)
    begin
      error_cnt++;
      $display("[FAIL] %0t wait ran out", $time);
      report_and_stop();
    end
  endtask : tmo
  // Results are compared at the handshake edge, where the answer is sampled.
  always @(posedge clk)
  begin
    if (trigger_hit === 1'b1) hits <= hits + 1;
    if (run_done === 1'b1) dones <= dones + 1;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk({32'h0, s_axi_bresp}, bq.pop_front());
  end
  task automatic axw(input logic [5:0] idx, input logic [7:0] d,
    input logic [3:0] st = 4'hf, input logic [1:0] er = `DTS_RESP_OKAY);
    int k;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bq.push_back({32'h0, er});
    for (k = 0; k < 64; k++)
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    tmo(k);
  endtask : axw
  task automatic axr(input logic [5:0] idx, input logic [7:0] d,
    input logic [1:0] er = `DTS_RESP_OKAY);
    int k;
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    // A late rready now and then makes the slave hold its read answer.
    s_axi_rready <= 1'($urandom());
    rq.push_back({er, 24'h0, d});
    for (k = 0; k < 64; k++)
    begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
      if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    tmo(k);
  endtask : axr
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    stim <= v;
    @(posedge clk);
    stim <= 8'h00;
  endtask : pulse
  task automatic far(input logic [3:0] c, input logic [3:0] r);
    @(posedge clk);
    cap_n <= c;
    rd_n <= r;
    cap_go <= c != 4'hf || r == 4'h0;
    rd_go <= r != 4'h0;
    @(posedge clk);
    cap_go <= 1'b0;
    rd_go <= 1'b0;
  endtask : far
  task automatic erst;
    @(posedge clk);
    end_run_rst <= 1'b1;
    @(posedge clk);
    end_run_rst <= 1'b0;
  endtask : erst
  // Disarm first, since the trigger register ignores writes while armed.
  task automatic arm_with(input logic [7:0] tv);
    axw(ix_ctl, 8'h80);
    axw(ix_trg, tv);
    axw(ix_ctl, 8'hc0);
  endtask : arm_with
  initial
  begin
    rnd = 8'($urandom(32));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    axr(ix_trg, 8'h40);
    axr(ix_sta, 8'h00);
    axr(ix_cnt, 8'h00);
    axr(6'h10, 8'h00, dec);
    axw(6'h10, 8'hff, 4'hf, dec);
    rnd = 8'($urandom());
    axw(ix_trg, rnd);
    axw(ix_trg, ~rnd, 4'he);
    axw(ix_sta, 8'hff);
    axr(ix_trg, rnd & 8'hcf);
    axr(ix_sta, 8'h00);
    for (m = 0; m < 16; m++)
    begin
      h0 = hits;
      arm_with(8'(m));
      pulse(8'h20);
      repeat (3) @(posedge clk);
      chk({33'h0, hits != h0}, {33'h0, mask_b[m]});
      h0 = hits;
      arm_with(8'(m));
      pulse(8'hc3);
      pulse(8'h20);
      pulse(8'h60);
      pulse(8'h82);
      repeat (3) @(posedge clk);
      chk({33'h0, hits != h0}, {33'h0, mask_abr[m]});
    end
    arm_with(8'h80);
    axw(ix_trg, 8'h07);
    axr(ix_trg, 8'h80);
    axr(ix_sta, 8'h01);
    h0 = hits;
    pulse(8'hc0);
    repeat (3) @(posedge clk);
    chk({33'h0, hits != h0}, 34'h0);
    pulse(8'h88);
    repeat (3) @(posedge clk);
    chk({33'h0, hits != h0}, 34'h1);
    far(4'h0, 4'h0);
    arm_with(8'h40);
    axr(ix_sta, 8'h01);
    pulse(8'h10);
    pulse(8'h20);
    axr(ix_sta, 8'h61);
    far(4'he, 4'h0);
    h0 = dones;
    pulse(8'h40);
    for (n = 0; n < 64 && dones == h0; n++) @(posedge clk);
    tmo(n);
    axr(ix_cnt, 8'h08);
    axr(ix_sta, 8'he0);
    far(4'hf, 4'h8);
    repeat (12) @(posedge clk);
    axr(ix_cnt, 8'h08);
    axw(ix_trg, 8'h47);
    erst();
    axr(ix_trg, 8'h40);
    axr(ix_cnt, 8'h00);
    axr(ix_sta, 8'h00);
    far(4'h0, 4'h0);
    arm_with(8'h00);
    pulse(8'h20);
    far(4'h3, 4'h0);
    repeat (6) @(posedge clk);
    erst();
    axr(ix_trg, 8'h00);
    axr(ix_cnt, 8'h03);
    axr(ix_sta, 8'h40);
    axw(ix_ctl, 8'hc0);
    axr(ix_cnt, 8'h00);
    axr(ix_sta, 8'h01);
    report_and_stop();
  end
endmodule : dts_top_test
`default_nettype wire
